// [riap_consts.vh]
// offsets, fixed data values and timing counts of the remote interrupt acknowledge proxy
`ifndef RIAP_CONSTS_VH
`define RIAP_CONSTS_VH

// register offsets, byte addresses on the register port
`define RIAP_OFS_IRQ_LEVEL1_ACK 6'h32
`define RIAP_OFS_IRQ_LEVEL2_ACK 6'h34
`define RIAP_OFS_IRQ_LEVEL3_ACK 6'h36
`define RIAP_OFS_IRQ_LEVEL4_ACK 6'h38
`define RIAP_OFS_IRQ_LEVEL5_ACK 6'h3A
`define RIAP_OFS_IRQ_LEVEL6_ACK 6'h3C
`define RIAP_OFS_IRQ_LEVEL7_ACK 6'h3E
`define RIAP_OFS_SYNC_TRIGGER_REARM 6'h34
`define RIAP_OFS_ASYNC_TRIGGER_REARM 6'h36

// base from which an acknowledge offset maps to its level: level = (offset - base) / 2
`define RIAP_ACK_LEVEL_BASE 6'h30

// fixed read answers
`define RIAP_BACKPLANE_ACK_RDATA 16'hFFFF
`define RIAP_FAILED_ACK_RDATA 16'hFFFF
`define RIAP_UNMAPPED_RDATA 16'h0000

// reset values
`define RIAP_RST_FLAG 1'b0
`define RIAP_RST_LEVEL 3'h0

// timing: clock period and longest wait for the backplane handshake
`define RIAP_CLK_PERIOD_NS 10
`define RIAP_IACK_TIMEOUT_NS 10000
// 10 us at the 10 ns clock, sized to match the 16-bit timeout parameter
`define RIAP_IACK_TIMEOUT_CYC 16'h03E8

`endif

// [riap_trigger_watch.v]
// trigger source synchroniser and selected-source change detector
`timescale 1ns/100ps
`include "riap_consts.vh"

module riap_trigger_watch #(
  parameter SRC_W = 16,
  parameter SEL_W = 4
) (
  input wire clk_sys,
  input wire rst,
  input wire [SRC_W-1:0] trig_in,
  input wire [SEL_W-1:0] sel,
  output reg change_r
);

  reg [SRC_W-1:0] sync1_r;
  reg [SRC_W-1:0] sync2_r;
  reg [SRC_W-1:0] sync3_r;
  reg [SRC_W-1:0] level_r;
  reg [1:0] prime_r;
  wire [SRC_W-1:0] agree;
  wire primed;

  // a bit counts only once the second and third stages agree
  assign agree = ~(sync2_r ^ sync3_r);
  assign primed = (prime_r == 2'h3);

  // three-stage synchroniser, settled levels and one-cycle change pulse
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      sync1_r <= {SRC_W{1'b0}};
      sync2_r <= {SRC_W{1'b0}};
      sync3_r <= {SRC_W{1'b0}};
      level_r <= {SRC_W{1'b0}};
      prime_r <= 2'h0;
      change_r <= 1'b0;
    end
    else
    begin
      sync1_r <= trig_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      if (!primed)
      begin
        // adopt the pin levels after reset; the second stage already holds them, so no false change follows
        prime_r <= prime_r + 2'h1;
        level_r <= sync2_r;
        change_r <= 1'b0;
      end
      else
      begin
        level_r <= (level_r & ~agree) | (sync3_r & agree);
        change_r <= agree[sel] & (sync3_r[sel] != level_r[sel]);
      end
    end
  end

endmodule // riap_trigger_watch

// [riap_remote_iack_proxy.v]
// remote interrupt acknowledge proxy: acknowledge registers, trigger flag re-arm and backplane handshake
//
// Overview of operation
// - write at 0x36 re-arms trigger flag, unless the selected trigger changes in that cycle
// - seven read-only acknowledge registers, 0x32 to 0x3E
// - read runs acknowledge cycle, returns status/ID
// - only cable-side master reads start the cycle
// - backplane master reads return FFFF, no cycle
// - register address alone selects acknowledge level
// - selected trigger change sets flag until re-armed
`timescale 1ns/100ps
`include "riap_consts.vh"

module riap_remote_iack_proxy #(
  parameter DATA_W = 16,
  parameter ADDR_W = 6,
  parameter TRIG_W = 16,
  parameter SEL_W = 4,
  parameter TMO_W = 16,
  parameter [15:0] IACK_TIMEOUT_CYC = `RIAP_IACK_TIMEOUT_CYC
) (
  input wire clk_sys,
  input wire rst,
  // register port
  input wire reg_req,
  input wire reg_wr,
  input wire [ADDR_W-1:0] reg_addr,
  input wire [DATA_W-1:0] reg_wdata,
  input wire reg_from_cable,
  output reg reg_ack_r,
  output reg [DATA_W-1:0] reg_rdata_r,
  output reg reg_err_r,
  output reg reg_busy_r,
  // backplane interrupt acknowledge handshake
  output reg vme_iack_n_r,
  output reg vme_as_n_r,
  output reg vme_ds_n_r,
  output reg [2:0] vme_iack_level_r,
  input wire vme_dtack_n,
  input wire vme_berr_n,
  input wire [DATA_W-1:0] vme_data,
  // trigger flag
  input wire [TRIG_W-1:0] trig_in,
  input wire [SEL_W-1:0] internal_trigger_select,
  output reg async_trigger_int_flag_r,
  output reg sync_trigger_rearm_r
);

  // handshake states
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_SETUP = 3'h1;
  localparam [2:0] ST_WAIT = 3'h2;
  localparam [2:0] ST_RELEASE = 3'h3;
  localparam [2:0] ST_ANSWER = 3'h4;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [TMO_W-1:0] tmo_cnt_r;
  reg [DATA_W-1:0] id_r;
  reg fail_r;

  // pin synchronisers
  reg dtack_s1_r;
  reg dtack_s2_r;
  reg dtack_s3_r;
  reg berr_s1_r;
  reg berr_s2_r;
  reg berr_s3_r;
  reg [DATA_W-1:0] data_s1_r;
  reg [DATA_W-1:0] data_s2_r;
  reg [DATA_W-1:0] data_s3_r;

  wire dtack_low;
  wire dtack_high;
  wire berr_low;
  wire tmo_hit;
  wire take;
  wire [2:0] req_level;
  wire trig_change;
  wire rearm_async;

  // level of an acknowledge offset, zero when the offset is none of them
  function [2:0] ack_level;
    input [ADDR_W-1:0] addr;
    reg [ADDR_W-1:0] diff;
    begin
      diff = addr - `RIAP_ACK_LEVEL_BASE;
      if (addr >= `RIAP_OFS_IRQ_LEVEL1_ACK && addr <= `RIAP_OFS_IRQ_LEVEL7_ACK && !addr[0])
        ack_level = diff[3:1];
      else
        ack_level = 3'h0;
    end
  endfunction

  // requests are only taken while no acknowledge cycle is in flight
  assign take = reg_req & ~reg_busy_r;
  assign req_level = ack_level(reg_addr);
  assign rearm_async = take & reg_wr & (reg_addr == `RIAP_OFS_ASYNC_TRIGGER_REARM);

  // levels count once second and third stages agree
  assign dtack_low = ~dtack_s2_r & ~dtack_s3_r;
  assign dtack_high = dtack_s2_r & dtack_s3_r;
  assign berr_low = ~berr_s2_r & ~berr_s3_r;
  assign tmo_hit = (tmo_cnt_r >= IACK_TIMEOUT_CYC);

  // watches the selected trigger source for a change
  riap_trigger_watch #(
    .SRC_W(TRIG_W),
    .SEL_W(SEL_W)
  ) u_trigger_watch (
    .clk_sys(clk_sys),
    .rst(rst),
    .trig_in(trig_in),
    .sel(internal_trigger_select),
    .change_r(trig_change)
  );

  // three-stage synchronisers for the handshake pins and the status/ID lines
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      dtack_s1_r <= 1'b1;
      dtack_s2_r <= 1'b1;
      dtack_s3_r <= 1'b1;
      berr_s1_r <= 1'b1;
      berr_s2_r <= 1'b1;
      berr_s3_r <= 1'b1;
      data_s1_r <= {DATA_W{1'b0}};
      data_s2_r <= {DATA_W{1'b0}};
      data_s3_r <= {DATA_W{1'b0}};
    end
    else
    begin
      dtack_s1_r <= vme_dtack_n;
      dtack_s2_r <= dtack_s1_r;
      dtack_s3_r <= dtack_s2_r;
      berr_s1_r <= vme_berr_n;
      berr_s2_r <= berr_s1_r;
      berr_s3_r <= berr_s2_r;
      data_s1_r <= vme_data;
      data_s2_r <= data_s1_r;
      data_s3_r <= data_s2_r;
    end
  end

  // next state of the acknowledge handshake
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
      begin
        if (take && !reg_wr && reg_from_cable && req_level != 3'h0)
          state_nxt = ST_SETUP;
      end
      ST_SETUP:
        state_nxt = ST_WAIT;
      ST_WAIT:
      begin
        if (dtack_low || berr_low || tmo_hit)
          state_nxt = ST_RELEASE;
      end
      ST_RELEASE:
      begin
        // wait for the interrupter to let go, or for the timeout, before the next cycle may start
        if ((dtack_high && !berr_low) || tmo_hit)
          state_nxt = ST_ANSWER;
      end
      ST_ANSWER:
        state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  // handshake registers and strobes on the backplane
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_r <= ST_IDLE;
      tmo_cnt_r <= {TMO_W{1'b0}};
      id_r <= {DATA_W{1'b0}};
      fail_r <= 1'b0;
      vme_iack_n_r <= 1'b1;
      vme_as_n_r <= 1'b1;
      vme_ds_n_r <= 1'b1;
      vme_iack_level_r <= `RIAP_RST_LEVEL;
    end
    else
    begin
      state_r <= state_nxt;
      case (state_r)
        ST_IDLE:
        begin
          tmo_cnt_r <= {TMO_W{1'b0}};
          if (state_nxt == ST_SETUP)
          begin
            // the offset alone picks the level driven on the backplane
            vme_iack_level_r <= req_level;
            vme_iack_n_r <= 1'b0;
            fail_r <= 1'b0;
          end
        end
        ST_SETUP:
        begin
          vme_as_n_r <= 1'b0;
          vme_ds_n_r <= 1'b0;
        end
        ST_WAIT:
        begin
          tmo_cnt_r <= tmo_cnt_r + {{(TMO_W-1){1'b0}}, 1'b1};
          if (state_nxt == ST_RELEASE)
          begin
            // status/ID is taken while the interrupter still holds it
            if (dtack_low && !berr_low)
              id_r <= data_s3_r;
            else
              id_r <= `RIAP_FAILED_ACK_RDATA;
            fail_r <= ~dtack_low | berr_low;
            tmo_cnt_r <= {TMO_W{1'b0}};
            vme_as_n_r <= 1'b1;
            vme_ds_n_r <= 1'b1;
            vme_iack_n_r <= 1'b1;
          end
        end
        ST_RELEASE:
        begin
          tmo_cnt_r <= tmo_cnt_r + {{(TMO_W-1){1'b0}}, 1'b1};
          if (state_nxt == ST_ANSWER)
            vme_iack_level_r <= `RIAP_RST_LEVEL;
        end
        ST_ANSWER:
          tmo_cnt_r <= {TMO_W{1'b0}};
        default:
        begin
          vme_as_n_r <= 1'b1;
          vme_ds_n_r <= 1'b1;
          vme_iack_n_r <= 1'b1;
        end
      endcase
    end
  end

  // register port answers: immediate for writes, unmapped reads and local reads, after the handshake otherwise
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      reg_ack_r <= 1'b0;
      reg_rdata_r <= {DATA_W{1'b0}};
      reg_err_r <= 1'b0;
      reg_busy_r <= 1'b0;
    end
    else
    begin
      reg_ack_r <= 1'b0;
      reg_err_r <= 1'b0;
      if (state_r == ST_ANSWER)
      begin
        reg_ack_r <= 1'b1;
        reg_rdata_r <= id_r;
        reg_err_r <= fail_r;
        reg_busy_r <= 1'b0;
      end
      else if (take)
      begin
        if (reg_wr)
        begin
          // write data is ignored; only the offset matters
          reg_ack_r <= 1'b1;
          reg_rdata_r <= {DATA_W{1'b0}};
        end
        else if (req_level == 3'h0)
        begin
          reg_ack_r <= 1'b1;
          reg_rdata_r <= `RIAP_UNMAPPED_RDATA;
        end
        else if (!reg_from_cable)
        begin
          // a backplane master gets the constant and starts nothing
          reg_ack_r <= 1'b1;
          reg_rdata_r <= `RIAP_BACKPLANE_ACK_RDATA;
        end
        else
          reg_busy_r <= 1'b1;
      end
    end
  end

  // trigger flag and re-arm strobes; a change in the re-arm cycle keeps the flag set
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      async_trigger_int_flag_r <= `RIAP_RST_FLAG;
      sync_trigger_rearm_r <= 1'b0;
    end
    else
    begin
      if (trig_change)
        async_trigger_int_flag_r <= 1'b1;
      else if (rearm_async)
        async_trigger_int_flag_r <= 1'b0;
      sync_trigger_rearm_r <= take & reg_wr & (reg_addr == `RIAP_OFS_SYNC_TRIGGER_REARM);
    end
  end

endmodule // riap_remote_iack_proxy

// [riap_chk.sv]
// port-level properties of the remote interrupt acknowledge proxy
`timescale 1ns/100ps
module riap_chk (
  input wire clk_sys,
  input wire rst,
  input wire reg_req,
  input wire reg_wr,
  input wire [5:0] reg_addr,
  input wire reg_from_cable,
  input wire reg_ack_r,
  input wire [15:0] reg_rdata_r,
  input wire reg_busy_r,
  input wire vme_iack_n_r,
  input wire vme_as_n_r,
  input wire vme_ds_n_r,
  input wire [2:0] vme_iack_level_r,
  input wire async_trigger_int_flag_r,
  input wire sync_trigger_rearm_r
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // a request is taken only while idle
  wire take = reg_req && !reg_busy_r;
  wire ack_adr = !reg_addr[0] && reg_addr >= 6'h32 && reg_addr <= 6'h3E;
  wire rearm_wr = take && reg_wr && reg_addr == 6'h36;
  sequence s_rd(c); take && !reg_wr && ack_adr && reg_from_cable == c; endsequence
  sequence s_wr(a); take && reg_wr && reg_addr == a; endsequence
  property p_rearm; s_wr(6'h36) |=> reg_ack_r && !sync_trigger_rearm_r && !reg_busy_r; endproperty
  a_rearm: assert property (p_rearm) else $error("bad rearm");
  property p_ro; take && !reg_wr |=> !sync_trigger_rearm_r; endproperty
  a_ro: assert property (p_ro) else $error("read strobed");
  property p_ends; $rose(reg_busy_r) |-> reg_busy_r [*3] ##[1:60] (reg_ack_r && !reg_busy_r); endproperty
  a_ends: assert property (p_ends) else $error("no end");
  property p_cable; $fell(vme_iack_n_r) |-> $rose(reg_busy_r) && $past(reg_from_cable); endproperty
  a_cable: assert property (p_cable) else $error("bad start");
  property p_bp; s_rd(1'b0) |=> reg_ack_r && reg_rdata_r == 16'hFFFF && vme_iack_n_r; endproperty
  a_bp: assert property (p_bp) else $error("bad local read");
  property p_lvl; s_rd(1'b1) |=> !vme_iack_n_r && vme_iack_level_r == $past(reg_addr[3:1]); endproperty
  a_lvl: assert property (p_lvl) else $error("bad level");
  property p_hold; async_trigger_int_flag_r && !(take && reg_wr && reg_addr == 6'h36) |=> async_trigger_int_flag_r;
  endproperty
  a_hold: assert property (p_hold) else $error("flag lost");
  property p_sync; s_wr(6'h34) |=> sync_trigger_rearm_r && reg_ack_r && vme_iack_n_r; endproperty
  a_sync: assert property (p_sync) else $error("bad 34 write");
  property p_clear; $fell(async_trigger_int_flag_r) |-> $past(rearm_wr); endproperty
  a_clear: assert property (p_clear) else $error("flag cleared without rearm");
  property p_strb; !vme_as_n_r |-> !vme_ds_n_r && !vme_iack_n_r && reg_busy_r && vme_iack_level_r != 3'h0; endproperty
  a_strb: assert property (p_strb) else $error("strobe outside ack cycle");
endmodule // riap_chk
bind riap_remote_iack_proxy riap_chk riap_chk_i (.clk_sys(clk_sys), .rst(rst), .reg_req(reg_req),
  .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_from_cable(reg_from_cable), .reg_ack_r(reg_ack_r),
  .reg_rdata_r(reg_rdata_r), .reg_busy_r(reg_busy_r), .vme_iack_n_r(vme_iack_n_r),
  .vme_as_n_r(vme_as_n_r), .vme_ds_n_r(vme_ds_n_r),
  .vme_iack_level_r(vme_iack_level_r), .async_trigger_int_flag_r(async_trigger_int_flag_r),
  .sync_trigger_rearm_r(sync_trigger_rearm_r));

// [riap_vme_model.sv]
// behavioural backplane interrupter answering acknowledge cycles
`timescale 1ns/100ps
module riap_vme_model (
  input wire clk_sys,
  input wire iack_n,
  input wire ds_n,
  input wire [2:0] level,
  input wire [1:0] mode,
  input wire [31:0] dly,
  input wire [15:0] id_base,
  output reg dtack_n,
  output reg berr_n,
  output reg [15:0] data,
  output reg [2:0] last_level,
  output integer acks
);
  integer n;
  initial
  begin
    dtack_n = 1'b1;
    berr_n = 1'b1;
    data = 16'h5A5A;
    last_level = 3'h0;
    acks = 0;
  end
  // mode 0 answers, 1 bus error, 2 stays mute, 3 answers but holds dtack for 30 cycles
  always
  begin
    @(posedge clk_sys) #1;
    if (!ds_n && !iack_n)
    begin
      acks = acks + 1;
      last_level = level;
      for (n = 0; n < dly; n = n + 1) @(posedge clk_sys) #1;
      data = id_base ^ {13'h0, level};
      @(posedge clk_sys) #1;
      if (mode == 2'd1) berr_n = 1'b0;
      else if (mode != 2'd2) dtack_n = 1'b0;
      for (n = 0; n < 200 && (mode == 2'd3 ? n < 30 : !ds_n); n = n + 1) @(posedge clk_sys) #1;
      dtack_n = 1'b1;
      berr_n = 1'b1;
      data = ~data; // released bus shows no stale id
    end
  end
endmodule // riap_vme_model

// [testbench.sv]
// self-checking testbench of the remote interrupt acknowledge proxy
`timescale 1ns/100ps
`define CK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module testbench;
  reg clk_sys, rst, reg_req, reg_wr, reg_from_cable, er;
  reg [5:0] reg_addr;
  reg [6:0] ad;
  reg [15:0] reg_wdata, trig_in, id_base, rd;
  reg [3:0] internal_trigger_select;
  reg [1:0] mode;
  integer dly, fails, comparisons, seed, i, a0;
  wire reg_ack_r, reg_err_r, reg_busy_r, vme_iack_n_r, vme_as_n_r, vme_ds_n_r, dtack_n, berr_n, flag, srearm;
  wire [15:0] reg_rdata_r, vme_data;
  wire [2:0] vme_iack_level_r, last_level;
  wire [31:0] acks;
  riap_remote_iack_proxy #(.IACK_TIMEOUT_CYC(16'h0014)) riap_remote_iack_proxy_i (.clk_sys(clk_sys), .rst(rst),
    .reg_req(reg_req), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_from_cable(reg_from_cable),
    .reg_ack_r(reg_ack_r), .reg_rdata_r(reg_rdata_r), .reg_err_r(reg_err_r), .reg_busy_r(reg_busy_r),
    .vme_iack_n_r(vme_iack_n_r), .vme_as_n_r(vme_as_n_r), .vme_ds_n_r(vme_ds_n_r), .vme_iack_level_r(vme_iack_level_r),
    .vme_dtack_n(dtack_n), .vme_berr_n(berr_n), .vme_data(vme_data), .trig_in(trig_in),
    .internal_trigger_select(internal_trigger_select), .async_trigger_int_flag_r(flag), .sync_trigger_rearm_r(srearm));
  riap_vme_model riap_vme_model_i (.clk_sys(clk_sys), .iack_n(vme_iack_n_r), .ds_n(vme_ds_n_r),
    .level(vme_iack_level_r), .mode(mode), .dly(dly), .id_base(id_base), .dtack_n(dtack_n), .berr_n(berr_n),
    .data(vme_data), .last_level(last_level), .acks(acks));
  // clock
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task wrap_up;
  begin
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  end
  endtask
  // one register access, waits for the answer
  task acc(input w, input [5:0] a, input c);
    integer n;
  begin
    @(posedge clk_sys);
    reg_req <= 1'b1; reg_wr <= w; reg_addr <= a; reg_from_cable <= c; reg_wdata <= $random(seed);
    @(posedge clk_sys);
    reg_req <= 1'b0;
    #1;
    for (n = 0; n < 200 && reg_ack_r !== 1'b1; n++) @(posedge clk_sys) #1;
    if (n == 200) begin fails++; $display("BAD %0t no answer", $time); wrap_up; end
    rd = reg_rdata_r;
    er = reg_err_r;
  end
  endtask
  // reference read: data, error and backplane cycle count
  task rd_chk(input [5:0] a, input c);
    reg ok, f;
  begin
    ok = !a[0] && a >= 6'h32 && a <= 6'h3E;
    f = mode == 2'd1 || mode == 2'd2;
    a0 = acks;
    acc(1'b0, a, c);
    `CK(rd, !ok ? 16'h0000 : (!c || f) ? 16'hFFFF : id_base ^ {13'h0, a[3:1]})
    `CK({er, acks - a0}, {ok && c && f, 31'h0, ok && c})
    `CK({vme_as_n_r, vme_ds_n_r, vme_iack_n_r}, 3'b111)
    if (ok && c) `CK(last_level, a[3:1])
  end
  endtask
  initial
  begin
    seed = 32'h8d49c55a; fails = 0; comparisons = 0; rst = 1'b1; reg_req = 0; reg_wr = 0; reg_addr = 6'h00;
    reg_wdata = 16'h0000; reg_from_cable = 0; mode = 2'd0; dly = 0;
    trig_in = $random(seed); internal_trigger_select = $random(seed); id_base = $random(seed);
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    `CK({reg_busy_r, vme_iack_n_r, flag, vme_iack_level_r}, 6'b010000)
    $display("test reset done");
    for (ad = 7'h32; ad <= 7'h3E; ad = ad + 7'h02) begin dly = $random(seed) & 3; rd_chk(ad[5:0], 1'b1); end
    for (ad = 7'h32; ad <= 7'h3E; ad = ad + 7'h02) rd_chk(ad[5:0], 1'b0);
    rd_chk(6'h33, 1'b1);
    rd_chk(6'h20, 1'b1);
    $display("test levels done");
    for (i = 1; i < 4; i++) begin mode = i; rd_chk(6'h3A, 1'b1); end
    // the holding interrupter of mode 3 must let go before the next cycle
    repeat (10) @(posedge clk_sys);
    mode = 2'd0;
    acc(1'b1, 6'h34, 1'b1);
    `CK({srearm, vme_iack_n_r}, 2'b11)
    rd_chk(6'h34, 1'b1);
    $display("test faults done");
    @(posedge clk_sys) trig_in <= trig_in ^ (16'h1 << (internal_trigger_select + 4'h1));
    repeat (8) @(posedge clk_sys);
    #1 `CK(flag, 1'b0)
    @(posedge clk_sys) trig_in <= trig_in ^ (16'h1 << internal_trigger_select);
    for (i = 0; i < 12 && flag !== 1'b1; i++) @(posedge clk_sys) #1;
    `CK(flag, 1'b1)
    rd_chk(6'h36, 1'b0);
    `CK(flag, 1'b1)
    acc(1'b1, 6'h36, 1'b1);
    `CK({flag, srearm}, 2'b00)
    $display("test trigger done");
    for (i = 0; i < 20; i++) begin dly = $random(seed) & 7; rd_chk(6'h30 + ($random(seed) & 15), $random(seed)); end
    $display("test random done");
    wrap_up;
  end
endmodule // testbench
